// [rtl/ris_pkg.sv]
package ris_pkg;

  // ****************************************************************
  // Selector fields
  // ****************************************************************
  localparam int unsigned SEL_W      = 8;
  localparam int unsigned NUM_PINS   = 181;
  localparam int unsigned NUM_SEL    = 16;
  localparam int unsigned SEL_IDX_W  = 5;
  localparam logic [7:0]  SEL_GROUND = 8'h00;
  localparam logic [7:0]  SEL_RESET  = 8'h00;

  // Selector slot numbers, one per peripheral input
  localparam logic [4:0] S_EXT_IRQ1  = 5'h00;
  localparam logic [4:0] S_EXT_IRQ2  = 5'h01;
  localparam logic [4:0] S_TIMER1    = 5'h02;
  localparam logic [4:0] S_TIMER2    = 5'h03;
  localparam logic [4:0] S_TIMER3    = 5'h04;
  localparam logic [4:0] S_CAPTURE1  = 5'h05;
  localparam logic [4:0] S_CAPTURE2  = 5'h06;
  localparam logic [4:0] S_CAPTURE3  = 5'h07;
  localparam logic [4:0] S_CAPTURE4  = 5'h08;
  localparam logic [4:0] S_CMP_FAULT = 5'h09;
  localparam logic [4:0] S_PWM_FLT1  = 5'h0A;
  localparam logic [4:0] S_PWM_FLT2  = 5'h0B;
  localparam logic [4:0] S_PWM_FLT3  = 5'h0C;
  localparam logic [4:0] S_PWM_FLT4  = 5'h0D;
  localparam logic [4:0] S_SER1_RX   = 5'h0E;
  localparam logic [4:0] S_SER1_CTS  = 5'h0F;
  localparam logic [4:0] S_NONE      = 5'h1F;

  // ****************************************************************
  // Register map (byte addresses on APB, one word per register)
  // ****************************************************************
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned NUM_REGS = 10;
  localparam logic [7:0] EXT_IRQ1_INPUT_MAP_OFS      = 8'h00;
  localparam logic [7:0] EXT_IRQ2_INPUT_MAP_OFS      = 8'h04;
  localparam logic [7:0] TIMER1_CLOCK_INPUT_MAP_OFS  = 8'h08;
  localparam logic [7:0] TIMER23_CLOCK_INPUT_MAP_OFS = 8'h0C;
  localparam logic [7:0] CAPTURE12_INPUT_MAP_OFS     = 8'h10;
  localparam logic [7:0] CAPTURE34_INPUT_MAP_OFS     = 8'h14;
  localparam logic [7:0] COMPARE_FAULT_INPUT_MAP_OFS = 8'h18;
  localparam logic [7:0] PWM_FAULT12_INPUT_MAP_OFS   = 8'h1C;
  localparam logic [7:0] PWM_FAULT34_INPUT_MAP_OFS   = 8'h20;
  localparam logic [7:0] SERIAL1_INPUT_MAP_OFS       = 8'h24;

  // Field positions inside each 16-bit register
  localparam int unsigned HI_LSB = 8;
  localparam int unsigned LO_LSB = 0;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
    logic [3:0]        pstrb;
  } ris_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } ris_apb_rsp_t;

  typedef struct packed {
    logic serial1_cts;
    logic serial1_rx;
    logic pwm_fault4;
    logic pwm_fault3;
    logic pwm_fault2;
    logic pwm_fault1;
    logic compare_fault_a_input;
    logic capture4;
    logic capture3;
    logic capture2;
    logic capture1;
    logic timer3_ext_clock;
    logic timer2_ext_clock;
    logic timer1_ext_clock;
    logic ext_irq2_input;
    logic ext_irq1_input;
  } ris_periph_in_t;

  // Upper and lower slot of one register
  typedef struct packed {
    logic [4:0] hi;
    logic [4:0] lo;
  } ris_reg_slots_t;

endpackage : ris_pkg

// [rtl/ris_pin_select.sv]
`timescale 1ns/100ps
`default_nettype none

module ris_pin_select
  import ris_pkg::*;
#(
  parameter int unsigned PINS = ris_pkg::NUM_PINS
) (
  input  wire logic [PINS:1]      remappable_pin_n,
  input  wire logic [SEL_W-1:0]   pin_sel,
  output var  logic               selected
);

  // ****************************************************************
  // One selector: ground, a pin, or ground for codes past the last pin
  // ****************************************************************
  always_comb begin
    selected = 1'b0;
    if (pin_sel == SEL_GROUND) begin
      selected = 1'b0;
    end else if (32'(pin_sel) <= PINS) begin
      selected = remappable_pin_n[pin_sel];
    end else begin
      selected = 1'b0;
    end
  end

endmodule // ris_pin_select

`default_nettype wire

// [rtl/ris_input_selector.sv]
// Functional notes
// - Each selector is an 8-bit byte-lane field.
// - Code zero ties the input low.
// - Code n routes remappable pin n.
// - Selectors read/write, reset to zero.
// - Unimplemented bits ignore writes, read zero.
// - External interrupt 2 in low byte only.
// - Timer 1 clock in upper byte only.
// - Timer 3 high, timer 2 low byte.
// - Captures paired: 2/1 and 4/3.
// - Compare fault A in low byte only.
// - PWM faults paired: 2/1 and 4/3.
// - Serial 1 CTS high, receive low.
// - Many selectors may share one pin.
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module ris_input_selector
  import ris_pkg::*;
#(
  parameter int unsigned PINS = ris_pkg::NUM_PINS
) (
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire ris_pkg::ris_apb_req_t   apb_req,
  output var  ris_pkg::ris_apb_rsp_t   apb_rsp,
  input  wire logic [PINS:1]           remappable_pin_n,
  output var  ris_pkg::ris_periph_in_t periph_in
);
  import ris_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [NUM_SEL-1:0][SEL_W-1:0] sel;
    ris_apb_rsp_t                  rsp;
    ris_periph_in_t                periph;
  } ris_state_t;

  ris_state_t state;
  ris_state_t next_state;

  logic [NUM_SEL-1:0] routed;

  // ****************************************************************
  // Register decode
  // ****************************************************************
  // Which selector slots live in the register at this address
  function automatic ris_reg_slots_t reg_slots(input logic [ADDR_W-1:0] addr);
    ris_reg_slots_t s;
    s = '{hi: S_NONE, lo: S_NONE};
    if (addr == EXT_IRQ1_INPUT_MAP_OFS) begin
      s = '{hi: S_EXT_IRQ1, lo: S_NONE};
    end else if (addr == EXT_IRQ2_INPUT_MAP_OFS) begin
      s = '{hi: S_NONE, lo: S_EXT_IRQ2};
    end else if (addr == TIMER1_CLOCK_INPUT_MAP_OFS) begin
      s = '{hi: S_TIMER1, lo: S_NONE};
    end else if (addr == TIMER23_CLOCK_INPUT_MAP_OFS) begin
      s = '{hi: S_TIMER3, lo: S_TIMER2};
    end else if (addr == CAPTURE12_INPUT_MAP_OFS) begin
      s = '{hi: S_CAPTURE2, lo: S_CAPTURE1};
    end else if (addr == CAPTURE34_INPUT_MAP_OFS) begin
      s = '{hi: S_CAPTURE4, lo: S_CAPTURE3};
    end else if (addr == COMPARE_FAULT_INPUT_MAP_OFS) begin
      s = '{hi: S_NONE, lo: S_CMP_FAULT};
    end else if (addr == PWM_FAULT12_INPUT_MAP_OFS) begin
      s = '{hi: S_PWM_FLT2, lo: S_PWM_FLT1};
    end else if (addr == PWM_FAULT34_INPUT_MAP_OFS) begin
      s = '{hi: S_PWM_FLT4, lo: S_PWM_FLT3};
    end else if (addr == SERIAL1_INPUT_MAP_OFS) begin
      s = '{hi: S_SER1_CTS, lo: S_SER1_RX};
    end
    return s;
  endfunction

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
    logic m;
    m = 1'b0;
    if (addr == EXT_IRQ1_INPUT_MAP_OFS) begin
      m = 1'b1;
    end else if (addr == EXT_IRQ2_INPUT_MAP_OFS) begin
      m = 1'b1;
    end else if (addr == TIMER1_CLOCK_INPUT_MAP_OFS) begin
      m = 1'b1;
    end else if (addr == TIMER23_CLOCK_INPUT_MAP_OFS) begin
      m = 1'b1;
    end else if (addr == CAPTURE12_INPUT_MAP_OFS) begin
      m = 1'b1;
    end else if (addr == CAPTURE34_INPUT_MAP_OFS) begin
      m = 1'b1;
    end else if (addr == COMPARE_FAULT_INPUT_MAP_OFS) begin
      m = 1'b1;
    end else if (addr == PWM_FAULT12_INPUT_MAP_OFS) begin
      m = 1'b1;
    end else if (addr == PWM_FAULT34_INPUT_MAP_OFS) begin
      m = 1'b1;
    end else if (addr == SERIAL1_INPUT_MAP_OFS) begin
      m = 1'b1;
    end
    return m;
  endfunction

  // Value of one byte lane: the selector, or zero where no field sits
  function automatic logic [SEL_W-1:0] lane_value(
    input logic [NUM_SEL-1:0][SEL_W-1:0] sel,
    input logic [4:0]                    slot
  );
    logic [SEL_W-1:0] v;
    v = '0;
    if (slot != S_NONE) begin
      v = sel[slot[3:0]];
    end else begin
      v = '0;
    end
    return v;
  endfunction

  // ****************************************************************
  // Pin routing
  // ****************************************************************
  // Each selector has its own mux on the full pin bus, so any number
  // of them can watch the same pin, even one that also drives out.
  for (genvar g = 0; g < NUM_SEL; g++) begin : g_route
    ris_pin_select #(
      .PINS (PINS)
    ) u_pin_select (
      .remappable_pin_n (remappable_pin_n),
      .pin_sel          (state.sel[g]),
      .selected         (routed[g])
    );
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  logic             access;
  logic             wr_take;
  logic             mapped;
  ris_reg_slots_t   slots;
  logic [15:0]      rd_word;

  always_comb begin
    next_state = state;
    access     = apb_req.psel && apb_req.penable;
    mapped     = addr_mapped(apb_req.paddr);
    slots      = reg_slots(apb_req.paddr);
    rd_word    = {lane_value(state.sel, slots.hi), lane_value(state.sel, slots.lo)};

    // The slave answers one cycle into the access phase; pready is a
    // flop so that the reply never hangs on a combinational path.
    wr_take = access && state.rsp.pready && apb_req.pwrite && mapped;

    if (access && !state.rsp.pready) begin
      next_state.rsp.pready  = 1'b1;
      next_state.rsp.pslverr = !mapped;
      if (!apb_req.pwrite && mapped) begin
        next_state.rsp.prdata = {16'h0000, rd_word};
      end else begin
        next_state.rsp.prdata = 32'h0000_0000;
      end
    end else begin
      next_state.rsp.pready  = 1'b0;
      next_state.rsp.pslverr = 1'b0;
      next_state.rsp.prdata  = 32'h0000_0000;
    end

    // Writes land only at the edge that completes the transfer
    if (wr_take) begin
      if (slots.hi != S_NONE && apb_req.pstrb[1]) begin
        next_state.sel[slots.hi[3:0]] = apb_req.pwdata[HI_LSB +: SEL_W];
      end
      if (slots.lo != S_NONE && apb_req.pstrb[0]) begin
        next_state.sel[slots.lo[3:0]] = apb_req.pwdata[LO_LSB +: SEL_W];
      end
    end

    // Peripheral inputs are registered so every output leaves a flop
    next_state.periph.ext_irq1_input        = routed[S_EXT_IRQ1[3:0]];
    next_state.periph.ext_irq2_input        = routed[S_EXT_IRQ2[3:0]];
    next_state.periph.timer1_ext_clock      = routed[S_TIMER1[3:0]];
    next_state.periph.timer2_ext_clock      = routed[S_TIMER2[3:0]];
    next_state.periph.timer3_ext_clock      = routed[S_TIMER3[3:0]];
    next_state.periph.capture1              = routed[S_CAPTURE1[3:0]];
    next_state.periph.capture2              = routed[S_CAPTURE2[3:0]];
    next_state.periph.capture3              = routed[S_CAPTURE3[3:0]];
    next_state.periph.capture4              = routed[S_CAPTURE4[3:0]];
    next_state.periph.compare_fault_a_input = routed[S_CMP_FAULT[3:0]];
    next_state.periph.pwm_fault1            = routed[S_PWM_FLT1[3:0]];
    next_state.periph.pwm_fault2            = routed[S_PWM_FLT2[3:0]];
    next_state.periph.pwm_fault3            = routed[S_PWM_FLT3[3:0]];
    next_state.periph.pwm_fault4            = routed[S_PWM_FLT4[3:0]];
    next_state.periph.serial1_rx            = routed[S_SER1_RX[3:0]];
    next_state.periph.serial1_cts           = routed[S_SER1_CTS[3:0]];
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state.sel    <= {NUM_SEL{SEL_RESET}};
      state.rsp    <= '0;
      state.periph <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign apb_rsp   = state.rsp;
  assign periph_in = state.periph;

endmodule // ris_input_selector

`default_nettype wire

// [tb/ris_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module ris_chk
  import ris_pkg::*;
#(
  parameter int unsigned PINS = NUM_PINS
) (
  input wire logic                    clk,
  input wire logic                    resetn,
  input wire ris_pkg::ris_apb_req_t   apb_req,
  input wire ris_pkg::ris_apb_rsp_t   apb_rsp,
  input wire logic [PINS:1]           remappable_pin_n,
  input wire ris_pkg::ris_periph_in_t periph_in
);
  // ****************
  // Bus and routing
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire acc = apb_req.psel && apb_req.penable;
  wire rdy = apb_rsp.pready;
  wire [7:0] a = apb_req.paddr;
  ready_once_a: assert property (rdy |=> !rdy) else $error("pready held");
  ready_time_a: assert property (apb_req.psel && !apb_req.penable ##1 acc |=> rdy)
    else $error("pready late");
  ready_idle_a: assert property (!acc |-> !rdy) else $error("pready outside access");
  rdata_idle_a: assert property (!rdy |-> apb_rsp.prdata == 32'h0) else $error("prdata idle");
  upper_zero_a: assert property (rdy |-> apb_rsp.prdata[31:16] == 16'h0)
    else $error("upper half set");
  lo_lane_a: assert property (rdy && (a == 8'h00 || a == 8'h08) |-> apb_rsp.prdata[7:0] == 8'h0)
    else $error("low lane set");
  hi_lane_a: assert property (rdy && (a == 8'h04 || a == 8'h18) |-> apb_rsp.prdata[15:8] == 8'h0)
    else $error("high lane set");
  err_map_a: assert property (rdy && a > 8'h24 |-> apb_rsp.pslverr) else $error("no error");
  ok_map_a: assert property (rdy && a <= 8'h24 && a[1:0] == 2'b00 |-> !apb_rsp.pslverr)
    else $error("false error");
  reset_clear_a: assert property ($rose(resetn) |-> periph_in == '0 && !rdy)
    else $error("reset state");
  ground_a: assert property (remappable_pin_n == '0 |=> periph_in == '0)
    else $error("input high with pins low");
  cover property (rdy && apb_req.pwrite);
  cover property (rdy && !apb_req.pwrite);
  cover property (apb_rsp.pslverr);
  cover property (periph_in == 16'hFFFF);
endmodule // ris_chk
bind ris_input_selector ris_chk #(.PINS(PINS)) ris_chk_i (.clk(clk), .resetn(resetn),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .remappable_pin_n(remappable_pin_n),
  .periph_in(periph_in));
`default_nettype wire

// [tb/ris_pin_model.sv]
`timescale 1ns/100ps
`default_nettype none
module ris_pin_model #(
  parameter int unsigned PINS = 181
) (
  input  wire logic          clk,
  input  wire logic [7:0]    pin_idx,
  input  wire logic          pin_lvl,
  input  wire logic          pin_all,
  output var  logic [PINS:1] pins
);
  // **************
  // Pin levels
  // **************
  initial pins = '0;
  // Other pins take the opposite level so a wrong route shows
  always @(posedge clk) begin
    if (pin_all) begin
      pins <= {PINS{pin_lvl}};
    end else begin
      pins <= {PINS{~pin_lvl}};
      pins[pin_idx] <= pin_lvl;
    end
  end
endmodule // ris_pin_model
`default_nettype wire

// [tb/remappable_input_selector_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module remappable_input_selector_bench;
  import ris_pkg::*;
  // **************
  // Bench
  // **************
  localparam logic [15:0] MSK [10] = '{16'hFF00, 16'h00FF, 16'hFF00, 16'hFFFF, 16'hFFFF,
    16'hFFFF, 16'h00FF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
  localparam logic [15:0] PM [10] = '{16'h0001, 16'h0002, 16'h0004, 16'h0018, 16'h0060,
    16'h0180, 16'h0200, 16'h0C00, 16'h3000, 16'hC000};
  localparam logic [7:0] CS [3] = '{8'h00, 8'h01, 8'hB6};
  logic              clk, resetn, pin_lvl, pin_all, err;
  logic [7:0]        pin_idx;
  logic [31:0]       rdat;
  logic [NUM_PINS:1] pins;
  ris_apb_req_t      req;
  ris_apb_rsp_t      rsp;
  ris_periph_in_t    pout;
  int                bad_count = 0;
  int                checked = 0;
  ris_input_selector ris_input_selector_i (.clk(clk), .resetn(resetn), .apb_req(req),
    .apb_rsp(rsp), .remappable_pin_n(pins), .periph_in(pout));
  ris_pin_model ris_pin_model_i (.clk(clk), .pin_idx(pin_idx), .pin_lvl(pin_lvl),
    .pin_all(pin_all), .pins(pins));
  always #2.5 clk = ~clk;
  task automatic give_verdict();
    if (bad_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      bad_count++;
    end
  endtask
  task automatic xfer(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
                      input logic [3:0] st);
    int n;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: ad, pwdata: wd, pstrb: st};
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    // Look only at rising edges: pready and prdata are read as they stand
    // before the edge, so the request is still held when they are taken
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (rsp.pready !== 1'b1) begin
      chk("pready", 32'h1, 32'h0);
      give_verdict();
    end
    rdat = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic rd(input int r, input logic [31:0] exp);
    xfer(1'b0, 8'(r * 4), 32'h0, 4'h0);
    chk("read data", exp, rdat);
  endtask
  task automatic wall(input logic [31:0] d);
    for (int r = 0; r < 10; r++) xfer(1'b1, 8'(r * 4), d, 4'hF);
  endtask
  // Routing settles one edge after a write, two after a pin change
  task automatic setp(input logic [7:0] idx, input logic lvl, input logic all);
    @(posedge clk);
    pin_idx <= idx;
    pin_lvl <= lvl;
    pin_all <= all;
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    req = '0;
    pin_idx = 8'h00;
    pin_lvl = 1'b0;
    pin_all = 1'b1;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    for (int r = 0; r < 10; r++) rd(r, 32'h0);
    wall(32'hFFFF_FFFF);
    for (int r = 0; r < 10; r++) rd(r, {16'h0, MSK[r]});
    xfer(1'b1, 8'h10, 32'h0, 4'h2);
    rd(4, 32'h0000_00FF);
    xfer(1'b1, 8'h28, 32'hFFFF_FFFF, 4'hF);
    chk("write error", 32'h1, {31'h0, err});
    xfer(1'b0, 8'h28, 32'h0, 4'h0);
    chk("read error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rdat);
    wall(32'h0000_B5B5);
    setp(8'd181, 1'b1, 1'b0);
    chk("periph_in", 32'hFFFF, {16'h0, pout});
    setp(8'd181, 1'b0, 1'b0);
    chk("periph_in", 32'h0, {16'h0, pout});
    for (int r = 0; r < 10; r++) begin
      xfer(1'b1, 8'(r * 4), 32'h0000_B4B4, 4'hF);
      setp(8'd180, 1'b1, 1'b0);
      chk("periph_in", {16'h0, PM[r]}, {16'h0, pout});
      xfer(1'b1, 8'(r * 4), 32'h0000_B5B5, 4'hF);
    end
    for (int c = 0; c < 3; c++) begin
      wall({16'h0, CS[c], CS[c]});
      setp(8'h00, 1'b1, 1'b1);
      chk("periph_in", (CS[c] == 8'h01) ? 32'hFFFF : 32'h0, {16'h0, pout});
    end
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    for (int r = 0; r < 10; r++) rd(r, 32'h0);
    chk("periph_in", 32'h0, {16'h0, pout});
    give_verdict();
  end
endmodule // remappable_input_selector_bench
`default_nettype wire
